//--- ppf_framer.sv
// pre-pit disk-information block framer: builds 16-frame physical blocks
module ppf_framer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic frame_tick, // one frame slot, from pre-pit timing logic
    input wire logic [ppf_pkg::IDX_BITS-1:0] sector_idx, // groove sector low bits
    input wire logic [1:0] field_sel, // block type, taken at frame 0
    input wire logic [ppf_pkg::ADDR_BITS-1:0] ecc_addr, // block address of part a
    input wire logic layer_sel, // 0 layer 0, 1 layer 1
    input wire logic app_unrestricted, // application code position 6
    input wire logic [5:0] app_class, // application code positions 7 to 12
    input wire logic disk_small, // 1 for the smaller diameter disk
    input wire logic media_other, // 1 for non-dye recording layer
    input wire logic [ppf_pkg::ADDR_BITS-1:0] last_addr_l0, // final layer 0 address
    input wire logic [ppf_pkg::ADDR_BITS-1:0] last_addr_l1, // final layer 1 address
    input wire logic [3:0] version_num, // compatible version number
    output logic frame_valid, // one-cycle pulse per emitted frame
    output logic [ppf_pkg::FRAME_BITS-1:0] frame_word, // bit 12 = position 0
    output logic cfg_error, // last block start had an illegal type
    output logic app_reserved // last block start used a reserved class
);
    import ppf_pkg::*;

    // ----------------------------------------------------------------
    // field arithmetic
    // ----------------------------------------------------------------

    // multiply in gf(256) with the pre-pit primitive polynomial
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] acc;
        logic [7:0] sh;
        acc = 8'h00;
        sh = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                acc = acc ^ sh;
            end
            sh = sh[7] ? ({sh[6:0], 1'b0} ^ GP_LOW) : {sh[6:0], 1'b0};
        end
        return acc;
    endfunction

    // one division step of the parity remainder, high degree first
    function automatic logic [23:0] rs_step(input logic [23:0] st, input logic [7:0] d);
        logic [7:0] fb;
        fb = d ^ st[23:16];
        return {st[15:8] ^ gf_mul(fb, GEN_C2), st[7:0] ^ gf_mul(fb, GEN_C1),
                gf_mul(fb, GEN_C0)};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic active; // a legal block is in progress
    logic next_active;
    ppf_field_t field; // type of the block in progress
    ppf_field_t next_field;
    logic [ADDR_BITS-1:0] snap_addr; // part a address of the block
    logic [ADDR_BITS-1:0] next_snap_addr;
    logic [ADDR_BITS-1:0] snap_last; // final address for the block type
    logic [ADDR_BITS-1:0] next_snap_last;
    logic [7:0] snap_app; // application code byte
    logic [7:0] next_snap_app;
    logic [7:0] snap_phy; // physical code byte
    logic [7:0] next_snap_phy;
    logic [7:0] snap_misc; // layer byte or version byte
    logic [7:0] next_snap_misc;
    logic [23:0] parity; // running remainder, first parity byte on top
    logic [23:0] next_parity;
    logic next_frame_valid;
    logic [FRAME_BITS-1:0] next_frame_word;
    logic next_cfg_error;
    logic next_app_reserved;

    // ----------------------------------------------------------------
    // next-state and frame assembly
    // ----------------------------------------------------------------

    // block fields are frozen at frame 0; frame 0 itself uses live inputs
    always_comb begin
        logic start;
        logic emit;
        ppf_field_t cur_field;
        logic [ADDR_BITS-1:0] cur_addr;
        logic [ADDR_BITS-1:0] cur_last;
        logic [7:0] cur_app;
        logic [7:0] cur_phy;
        logic [7:0] cur_misc;
        logic [7:0] data;
        logic [23:0] par_in;
        start = 1'b0;
        emit = 1'b0;
        cur_field = field;
        cur_addr = snap_addr;
        cur_last = snap_last;
        cur_app = snap_app;
        cur_phy = snap_phy;
        cur_misc = snap_misc;
        data = BYTE_ZERO;
        par_in = parity;
        next_active = active;
        next_field = field;
        next_snap_addr = snap_addr;
        next_snap_last = snap_last;
        next_snap_app = snap_app;
        next_snap_phy = snap_phy;
        next_snap_misc = snap_misc;
        next_parity = parity;
        next_frame_valid = 1'b0;
        next_frame_word = frame_word;
        next_cfg_error = cfg_error;
        next_app_reserved = app_reserved;
        if (frame_tick) begin
            // blocks align to the groove sector count
            start = (sector_idx == FRM_FIRST);
            if (start) begin
                cur_field = ppf_field_t'(field_sel);
                cur_addr = ecc_addr;
                // no address gating: layer 0 blocks run on past the limit
                cur_last = (cur_field == PPF_FIELD_TWO) ? last_addr_l1 : last_addr_l0;
                cur_app = {APP_BIT5, app_unrestricted, app_class};
                cur_phy = {PHY_PITCH, PHY_VELOCITY, disk_small, PHY_REFL1,
                           PHY_REFL2, media_other, PHY_RECORDABLE, PHY_OPP_PATH};
                if (cur_field == PPF_FIELD_ZERO) begin
                    cur_misc = {layer_sel, LAYER_PAD};
                end else begin
                    cur_misc = {version_num, EXT_CODE};
                end
                next_active = (cur_field != PPF_FIELD_BAD);
                next_cfg_error = (cur_field == PPF_FIELD_BAD);
                // unrestricted media: every class but single layer is reserved
                next_app_reserved = app_unrestricted && (app_class != APP_CLASS_SINGLE);
                next_field = cur_field;
                next_snap_addr = cur_addr;
                next_snap_last = cur_last;
                next_snap_app = cur_app;
                next_snap_phy = cur_phy;
                next_snap_misc = cur_misc;
                emit = next_active;
            end else begin
                emit = active;
            end
            // byte for this frame
            unique case (sector_idx)
                4'h0: data = cur_addr[23:16];
                4'h1: data = cur_addr[15:8];
                4'h2: data = cur_addr[7:0];
                4'h3, 4'hd: data = parity[23:16];
                4'h4, 4'he: data = parity[15:8];
                4'h5, 4'hf: data = parity[7:0];
                4'h6: begin
                    unique case (cur_field)
                        PPF_FIELD_ONE: data = ID_TYPE_ONE;
                        PPF_FIELD_TWO: data = ID_TYPE_TWO;
                        default: data = ID_TYPE_ZERO;
                    endcase
                end
                4'h7: begin
                    unique case (cur_field)
                        PPF_FIELD_ONE: data = cur_app;
                        PPF_FIELD_TWO: data = BYTE_ZERO;
                        default: data = cur_addr[23:16];
                    endcase
                end
                4'h8: begin
                    unique case (cur_field)
                        PPF_FIELD_ONE: data = cur_phy;
                        PPF_FIELD_TWO: data = BYTE_ZERO;
                        default: data = cur_addr[15:8];
                    endcase
                end
                4'h9: begin
                    // types one and two: final address, most significant byte first; type zero: part b address low byte
                    if (cur_field == PPF_FIELD_ZERO) begin
                        data = cur_addr[7:0];
                    end else begin
                        data = cur_last[23:16];
                    end
                end
                4'ha: begin
                    if (cur_field == PPF_FIELD_ZERO) begin
                        data = cur_misc;
                    end else begin
                        data = cur_last[15:8];
                    end
                end
                4'hb: begin
                    if (cur_field == PPF_FIELD_ZERO) begin
                        data = BYTE_ZERO;
                    end else begin
                        data = cur_last[7:0];
                    end
                end
                4'hc: begin
                    // version in high nibble, extension code in low nibble
                    if (cur_field == PPF_FIELD_ONE) begin
                        data = cur_misc;
                    end else begin
                        data = BYTE_ZERO;
                    end
                end
                default: data = BYTE_ZERO;
            endcase
            if (emit) begin
                next_frame_valid = 1'b1;
                next_frame_word = {SYNC_MARK, sector_idx, data};
                // remainder restarts at each covered group
                if (sector_idx == FRM_FIRST || sector_idx == FRM_ID) begin
                    par_in = 24'h000000;
                end
                if (sector_idx < FRM_PAR_A0 ||
                    (sector_idx >= FRM_ID && sector_idx <= FRM_LAST_DATA)) begin
                    next_parity = rs_step(par_in, data);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // all state frozen while clk_en is low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            field <= PPF_FIELD_ZERO;
            snap_addr <= '0;
            snap_last <= '0;
            snap_app <= 8'h00;
            snap_phy <= 8'h00;
            snap_misc <= 8'h00;
            parity <= 24'h000000;
            frame_valid <= 1'b0;
            frame_word <= '0;
            cfg_error <= 1'b0;
            app_reserved <= 1'b0;
        end else if (clk_en) begin
            active <= next_active;
            field <= next_field;
            snap_addr <= next_snap_addr;
            snap_last <= next_snap_last;
            snap_app <= next_snap_app;
            snap_phy <= next_snap_phy;
            snap_misc <= next_snap_misc;
            parity <= next_parity;
            frame_valid <= next_frame_valid;
            frame_word <= next_frame_word;
            cfg_error <= next_cfg_error;
            app_reserved <= next_app_reserved;
        end
    end

endmodule

//--- ppf_framer_monitor.sv
// concurrent checks on the ports of the pre-pit block framer
module ppf_framer_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic frame_tick,
    input wire logic [3:0] sector_idx,
    input wire logic [1:0] field_sel,
    input wire logic frame_valid,
    input wire logic [12:0] frame_word,
    input wire logic cfg_error
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // helper: block type taken at the frame 0 tick
    // ----------------------------------------------------------------
    logic [1:0] blk_type; // type of the running block
    logic [3:0] idx; // index of the emitted frame
    assign idx = frame_word[11:8];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_type <= 2'h0;
        end else if (clk_en && frame_tick && sector_idx == 4'h0) begin
            blk_type <= field_sel;
        end
    end
    sequence s_take; frame_tick && clk_en; endsequence
    sequence s_bad_start; frame_tick && clk_en && sector_idx == 4'h0 && field_sel == 2'h3;
    endsequence
    property p_cause; frame_valid |-> $past(frame_tick && clk_en); endproperty
    property p_sync; frame_valid |-> frame_word[12] == 1'b1; endproperty
    property p_index; s_take ##1 frame_valid |-> idx == $past(sector_idx); endproperty
    property p_id; frame_valid && idx == 4'h6 |-> frame_word[7:0] == {6'h0, blk_type};
    endproperty
    property p_ext; frame_valid && idx == 4'hc && blk_type == 2'h1 |-> frame_word[3:0] == 4'h0;
    endproperty
    property p_phys; frame_valid && idx == 4'h8 && blk_type == 2'h1 |->
        (frame_word[7:0] & 8'hdb) == 8'h91; endproperty
    property p_app; frame_valid && idx == 4'h7 && blk_type == 2'h1 |-> !frame_word[7];
    endproperty
    property p_two_zero; frame_valid && blk_type == 2'h2 && idx inside {4'h7, 4'h8, 4'hc}
        |-> frame_word[7:0] == 8'h00; endproperty
    property p_layer; frame_valid && idx == 4'ha && blk_type == 2'h0 |->
        frame_word[6:0] == 7'h00; endproperty
    property p_bad; s_bad_start |=> cfg_error && !frame_valid; endproperty
    a_cause: assert property (p_cause) else $error("frame without a taken tick");
    a_sync: assert property (p_sync) else $error("sync mark missing");
    a_index: assert property (p_index) else $error("frame index wrong");
    a_id: assert property (p_id) else $error("identifier byte wrong");
    a_ext: assert property (p_ext) else $error("extension code not zero");
    a_phys: assert property (p_phys) else $error("physical code fixed bits wrong");
    a_app: assert property (p_app) else $error("application code bit set");
    a_two_zero: assert property (p_two_zero) else $error("type two filler wrong");
    a_layer: assert property (p_layer) else $error("layer byte padding wrong");
    a_bad: assert property (p_bad) else $error("illegal start not flagged");
endmodule
bind ppf_framer ppf_framer_monitor ppf_framer_monitor_inst (.*);

//--- ppf_pit_rx.sv
// drive-side decoder model: collects frames and checks both parity groups
module ppf_pit_rx (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic frame_valid,
    input wire logic [12:0] frame_word,
    output logic [12:0] words [16],
    output int n_frames,
    output logic par_a_ok,
    output logic par_b_ok
);
    import ppf_pkg::*;
    logic [23:0] rem_a, rem_b; // division remainders
    // gf(256) multiply, reduced by the field polynomial
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? GP_LOW : 8'h00);
        end
        return p;
    endfunction
    // one generator division step
    function automatic logic [23:0] step(input logic [23:0] r, input logic [7:0] c);
        logic [7:0] fb;
        fb = c ^ r[23:16];
        return {r[15:8] ^ gmul(fb, 8'h07), r[7:0] ^ gmul(fb, 8'h0e), gmul(fb, 8'h08)};
    endfunction
    // capture by frame index
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_frames <= 0;
        end else if (clr) begin
            n_frames <= 0;
        end else if (frame_valid) begin
            words[frame_word[11:8]] <= frame_word;
            n_frames <= n_frames + 1;
        end
    end
    // codeword remainders are zero when parity is right
    always_comb begin
        rem_a = 24'h0;
        rem_b = 24'h0;
        for (int j = 0; j < 16; j++) begin
            if (j < 6) rem_a = step(rem_a, words[j][7:0]);
            else rem_b = step(rem_b, words[j][7:0]);
        end
        par_a_ok = (rem_a == 24'h0);
        par_b_ok = (rem_b == 24'h0);
    end
endmodule

//--- ppf_pkg.sv
// constants for the pre-pit disk-information block framer
// Function
// - layer byte: identity in first bit, rest zero
// - type one: id 01, application, physical code
// - type one frames 9-11: layer 0 address
// - frame twelve extension code always 0000
// - version part equals compatible version number
// - application code: bit5 zero, restricted class coding
// - bit6 set: unrestricted, other classes reserved
// - physical code fixed bits as defined
// - physical bit 7: diameter, one is smaller
// - physical bit 10: organic dye zero, else one
// - type two: id 02, frames 7,8,12 zero
// - type two frames 9-11: layer 1 address
// - sync at position 0, index at 1-4
// - frame byte map, bit 5 msb
// - layer 0 blocks continue past final address
// - frame index equals groove sector low bits
// - two three-byte Reed-Solomon parity groups
package ppf_pkg;

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 13; // positions 0 to 12
    localparam int IDX_BITS = 4; // relative frame index width
    localparam int ADDR_BITS = 24; // three-byte block address
    localparam logic SYNC_MARK = 1'b1; // sync slot marker in position 0

    // frame numbers of interest
    localparam logic [3:0] FRM_FIRST = 4'h0; // block start, parity a reset
    localparam logic [3:0] FRM_PAR_A0 = 4'h3; // first parity a byte
    localparam logic [3:0] FRM_ID = 4'h6; // identifier byte, parity b reset
    localparam logic [3:0] FRM_LAST_DATA = 4'hc; // last byte covered by parity b

    // ----------------------------------------------------------------
    // field identifiers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PPF_FIELD_ZERO,
        PPF_FIELD_ONE,
        PPF_FIELD_TWO,
        PPF_FIELD_BAD
    } ppf_field_t;

    localparam logic [7:0] ID_TYPE_ZERO = 8'h00; // layer information block
    localparam logic [7:0] ID_TYPE_ONE = 8'h01; // info_type_one block
    localparam logic [7:0] ID_TYPE_TWO = 8'h02; // info_type_two block
    localparam logic [7:0] BYTE_ZERO = 8'h00; // filler byte

    // ----------------------------------------------------------------
    // code byte layouts (byte bit 7 = position 5)
    // ----------------------------------------------------------------
    localparam logic APP_BIT5 = 1'b0; // application code position 5
    localparam logic [5:0] APP_CLASS_SINGLE = 6'h00; // single layer, never flagged reserved
    localparam logic [5:0] APP_CLASS_DL0 = 6'h02; // dual-layer class 0
    localparam logic PHY_PITCH = 1'b1; // position 5
    localparam logic PHY_VELOCITY = 1'b0; // position 6
    localparam logic PHY_REFL1 = 1'b1; // position 8
    localparam logic PHY_REFL2 = 1'b0; // position 9
    localparam logic PHY_RECORDABLE = 1'b0; // position 11
    localparam logic PHY_OPP_PATH = 1'b1; // position 12
    localparam logic [3:0] EXT_CODE = 4'h0; // only legal extension code
    localparam logic [6:0] LAYER_PAD = 7'h00; // positions 6 to 12

    // ----------------------------------------------------------------
    // parity field: gp = x^8+x^4+x^3+x^2+1, g = x^3 + 7x^2 + 14x + 8
    // ----------------------------------------------------------------
    localparam logic [7:0] GP_LOW = 8'h1d; // reduction term of gp
    localparam logic [7:0] GEN_C2 = 8'h07;
    localparam logic [7:0] GEN_C1 = 8'h0e;
    localparam logic [7:0] GEN_C0 = 8'h08;

endpackage

//--- testbench.sv
// self-checking bench for the pre-pit block framer
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, clk_en, frame_tick, layer_sel, app_unrestricted, disk_small;
    logic media_other, frame_valid, cfg_error, app_reserved, clr, par_a_ok, par_b_ok;
    logic [3:0] sector_idx, version_num;
    logic [1:0] field_sel;
    logic [5:0] app_class;
    logic [23:0] ecc_addr, last_addr_l0, last_addr_l1;
    logic [12:0] frame_word;
    logic [12:0] words [16];
    int n_frames, n_fail, checked;
    ppf_framer ppf_framer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .frame_tick(frame_tick), .sector_idx(sector_idx), .field_sel(field_sel),
        .ecc_addr(ecc_addr), .layer_sel(layer_sel), .app_unrestricted(app_unrestricted),
        .app_class(app_class), .disk_small(disk_small), .media_other(media_other),
        .last_addr_l0(last_addr_l0), .last_addr_l1(last_addr_l1),
        .version_num(version_num), .frame_valid(frame_valid), .frame_word(frame_word),
        .cfg_error(cfg_error), .app_reserved(app_reserved));
    ppf_pit_rx ppf_pit_rx_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clr(clr),
        .frame_valid(frame_valid), .frame_word(frame_word), .words(words),
        .n_frames(n_frames), .par_a_ok(par_a_ok), .par_b_ok(par_b_ok));
    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // one compare for every kind of result
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // sixteen back-to-back ticks, then frame count, heads and parity
    task automatic send_block(input logic [1:0] f);
        @(negedge sys_clk) clr = 1'b1;
        @(negedge sys_clk) clr = 1'b0;
        field_sel = f;
        frame_tick = 1'b1;
        for (int i = 0; i < 16; i++) begin
            sector_idx = 4'(i);
            @(negedge sys_clk);
        end
        frame_tick = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("frame count", (f == 2'h3) ? 24'd0 : 24'd16, 24'(n_frames));
        if (f != 2'h3) begin
            for (int i = 0; i < 16; i++) chk("head", {1'b1, 4'(i)}, 24'(words[i][12:8]));
            chk("address", ecc_addr, {words[0][7:0], words[1][7:0], words[2][7:0]});
            chk("parity", 24'd3, {22'd0, par_a_ok, par_b_ok});
        end
    endtask
    // layer information block, both layers
    task automatic t_layer();
        ecc_addr = 24'hffd003;
        for (int l = 0; l < 2; l++) begin
            layer_sel = l[0];
            send_block(2'h0);
            chk("layer byte", {l[0], 7'h00}, 24'(words[10][7:0]));
            chk("id zero", 24'h0, 24'(words[6][7:0]));
            chk("part b address", ecc_addr, {words[7][7:0], words[8][7:0], words[9][7:0]});
            chk("layer fill", 24'h0, 24'({words[11][7:0], words[12][7:0]}));
        end
    endtask
    // ticks are ignored while the clock enable is low, an illegal start too
    task automatic t_freeze();
        @(negedge sys_clk) clr = 1'b1;
        @(negedge sys_clk) clr = 1'b0;
        clk_en = 1'b0;
        field_sel = 2'h3;
        sector_idx = 4'h0;
        frame_tick = 1'b1;
        repeat (3) @(negedge sys_clk);
        frame_tick = 1'b0;
        clk_en = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("frozen frames", 24'd0, 24'(n_frames));
        chk("frozen error", 24'h0, 24'(cfg_error));
    endtask
    // type one, restricted dye large disk then unrestricted other small disk
    task automatic t_type_one();
        for (int k = 0; k < 2; k++) begin
            {disk_small, media_other, app_unrestricted} = {3{k[0]}};
            app_class = k ? 6'h05 : 6'h02;
            version_num = k ? 4'h3 : 4'h0;
            last_addr_l0 = k ? 24'hfdd10a : 24'h000123;
            ecc_addr = 24'hfffffe; // outside the recordable zone
            send_block(2'h1);
            chk("id", 24'h01, 24'(words[6][7:0]));
            chk("app", {1'b0, k[0], app_class}, 24'(words[7][7:0]));
            chk("phys", {2'b10, k[0], 2'b10, k[0], 2'b01}, 24'(words[8][7:0]));
            chk("l0", last_addr_l0, {words[9][7:0], words[10][7:0], words[11][7:0]});
            chk("version", {version_num, 4'h0}, 24'(words[12][7:0]));
            chk("reserved", 24'(k), 24'(app_reserved));
        end
    endtask
    // type two, then an illegal start and recovery
    task automatic t_type_two_bad();
        last_addr_l1 = 24'h00332a;
        ecc_addr = 24'h00c000;
        send_block(2'h2);
        chk("id two", 24'h02, 24'(words[6][7:0]));
        chk("fill", 24'h0, {words[7][7:0], words[8][7:0], words[12][7:0]});
        chk("l1", last_addr_l1, {words[9][7:0], words[10][7:0], words[11][7:0]});
        send_block(2'h3);
        chk("cfg error", 24'h1, 24'(cfg_error));
        send_block(2'h2);
        chk("cfg clear", 24'h0, 24'(cfg_error));
    endtask
    // reset, then the scenarios
    initial begin
        {rst_n, frame_tick, layer_sel, app_unrestricted, disk_small, media_other, clr} = '0;
        clk_en = 1'b1;
        {sector_idx, version_num, field_sel, app_class} = '0;
        {ecc_addr, last_addr_l0, last_addr_l1} = '0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        t_layer();
        t_type_one();
        t_type_two_bad();
        t_freeze();
        end_of_test();
    end
endmodule
